// [design/tg_pkg.sv]
// constants, register map and mode codes of the timing generator
// assumes one 250 MHz system clock and byte-wide register port
package tg_pkg;

   // register offsets
   localparam logic [15:0] TBGC_ADDR = 16'h0036;
   localparam logic [15:0] SC1_ADDR = 16'h0038;
   localparam logic [15:0] SC2_ADDR = 16'h0039;

   // reset values
   localparam logic [7:0] TBGC_RST = 8'h00;
   localparam logic [7:0] SC1_RST = 8'h00;
   localparam logic [7:0] SC2_RST = 8'h80;

   // time_base_generator_control fields
   localparam int DV7_BIT = 4;
   localparam int TBEN_BIT = 3;
   localparam int TBCK_LSB = 0;

   // system_control_one fields
   localparam int STOP_BIT = 7;
   localparam int RELM_BIT = 6;
   localparam int RETM_BIT = 5;

   // system_control_two fields
   localparam int XEN_BIT = 7;
   localparam int SLOW_OSC_ENABLE_BIT = 6;
   localparam int MAIN_CLOCK_SELECT_BIT = 5;
   localparam int DOZE_BIT = 4;
   localparam int HALT_BIT = 2;
   localparam logic [7:0] SC2_WMASK = 8'hf4;

   // oscillator ticks counted as warm-up after stop release
   localparam logic [15:0] WARMUP_TICKS = 16'h0100;

   // output flag positions
   localparam int FL_CPU_HALT = 0;
   localparam int FL_PERIPH_EN = 1;
   localparam int FL_TBT_EN = 2;
   localparam int FL_FAST_ON = 3;
   localparam int FL_SLOW_ON = 4;
   localparam int FL_PINS_PORT = 5;
   localparam int FL_MAIN_SLOW = 6;

   typedef enum logic [3:0] {
      single_clock_fast_run = 4'h0,
      single_clock_doze = 4'h1,
      single_clock_deep_doze = 4'h2,
      fast_dual_run = 4'h3,
      fast_dual_doze = 4'h4,
      slow_dual_run = 4'h5,
      slow_only_run = 4'h6,
      slow_only_doze = 4'h7,
      slow_dual_doze = 4'h8,
      slow_deep_doze = 4'h9,
      stop_hold = 4'ha,
      stop_warm = 4'hb
   } mode_e;

endpackage

// [design/timing_generator_mode_control.sv]
// timing generator and operating-mode control of an 8-bit controller
// assumes fc/fs oscillator pins and stop pin are asynchronous; irq_req
// and master_interrupt_enable come from logic on clk_sys
`timescale 1ns/1ps
`default_nettype none

module timing_generator_mode_control (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic fc_clk,
   input wire logic fs_clk,
   input wire logic stop_pin,
   input wire logic irq_req,
   input wire logic master_interrupt_enable,
   output logic [3:0] mode,
   output logic cpu_halt,
   output logic wdt_halt,
   output logic periph_clk_en,
   output logic tbt_clk_en,
   output logic fast_osc_on,
   output logic slow_osc_on,
   output logic slow_pins_are_port,
   output logic main_clk_slow,
   output logic main_tick,
   output logic [1:0] machine_state,
   output logic [22:0] divider,
   output logic time_base_interrupt_set,
   output logic wake,
   output logic wake_service
);

   typedef struct packed {
      tg_pkg::mode_e mode;
      logic [7:0] tbgc;
      logic [7:0] sc1;
      logic [7:0] sc2;
      logic [1:0] pre;
      logic [5:0] lo;
      logic [14:0] hi;
      logic [1:0] mstate;
      logic [15:0] warm;
      logic ret_fast;
      logic from_fast;
      logic tb_entry_en;
      logic tap_prev;
      logic [2:0] fc_s;
      logic [2:0] fs_s;
      logic [2:0] stp_s;
      logic [7:0] rdata;
      logic [6:0] flags;
      logic main_tick;
      logic tb_set;
      logic wake;
      logic wake_svc;
   } state_s;

   localparam state_s RST_Q = '{
      mode: tg_pkg::single_clock_fast_run,
      tbgc: tg_pkg::TBGC_RST,
      sc1: tg_pkg::SC1_RST,
      sc2: tg_pkg::SC2_RST,
      flags: 7'h2e,
      default: '0
   };

   state_s q;
   state_s n;

   // slow modes other than slow dual run: fast oscillator off or divider front stopped
   function automatic logic front_stopped(input tg_pkg::mode_e m);
      front_stopped = (m == tg_pkg::slow_only_run) ||
         (m == tg_pkg::slow_only_doze) || (m == tg_pkg::slow_dual_doze) ||
         (m == tg_pkg::slow_deep_doze);
   endfunction

   // modes whose main clock is fs
   function automatic logic main_is_slow(input tg_pkg::mode_e m);
      main_is_slow = front_stopped(m) || (m == tg_pkg::slow_dual_run);
   endfunction

   // flag vector shown on the outputs for a mode
   function automatic logic [6:0] mode_flags(input tg_pkg::mode_e m,
                                             input logic slow_osc_enable,
                                             input logic ret_fast);
      logic run;
      logic deep;
      logic stp;
      logic single;
      logic [6:0] f;
      run = (m == tg_pkg::single_clock_fast_run) ||
         (m == tg_pkg::fast_dual_run) || (m == tg_pkg::slow_dual_run) ||
         (m == tg_pkg::slow_only_run);
      deep = (m == tg_pkg::single_clock_deep_doze) ||
         (m == tg_pkg::slow_deep_doze);
      stp = (m == tg_pkg::stop_hold) || (m == tg_pkg::stop_warm);
      single = (m == tg_pkg::single_clock_fast_run) ||
         (m == tg_pkg::single_clock_doze) ||
         (m == tg_pkg::single_clock_deep_doze);
      f = '0;
      f[tg_pkg::FL_CPU_HALT] = ~run;
      f[tg_pkg::FL_PERIPH_EN] = ~deep & ~stp;
      f[tg_pkg::FL_TBT_EN] = ~stp;
      f[tg_pkg::FL_FAST_ON] = stp ? (m == tg_pkg::stop_warm) & ret_fast :
         ~((m == tg_pkg::slow_only_run) || (m == tg_pkg::slow_only_doze) ||
           (m == tg_pkg::slow_deep_doze));
      f[tg_pkg::FL_SLOW_ON] = stp ? (m == tg_pkg::stop_warm) & ~ret_fast :
         ~single & slow_osc_enable;
      f[tg_pkg::FL_PINS_PORT] = single;
      f[tg_pkg::FL_MAIN_SLOW] = main_is_slow(m);
      mode_flags = f;
   endfunction

   // time-base source tap picked by the three select bits
   function automatic logic tb_tap(input logic [2:0] sel,
                                   input logic [14:0] hi);
      unique case (sel)
         3'h0: tb_tap = hi[14];
         3'h1: tb_tap = hi[12];
         3'h2: tb_tap = hi[10];
         3'h3: tb_tap = hi[7];
         3'h4: tb_tap = hi[6];
         3'h5: tb_tap = hi[5];
         3'h6: tb_tap = hi[4];
         3'h7: tb_tap = hi[2];
      endcase
   endfunction

   logic fc_tick;
   logic fs_tick;
   logic stp_rise;
   logic stp_lvl;
   logic pre_carry;
   logic lo_carry;
   logic in7;
   logic tap_now;
   logic tap_fall;
   logic wr_tbgc;
   logic wr_sc1;
   logic wr_sc2;
   logic clr_div;
   logic go_stop;
   logic [7:0] sc2_rd;

   // next-state logic; oscillator pins are sampled into tick pulses
   always_comb begin
      n = q;
      n.main_tick = 1'b0;
      n.tb_set = 1'b0;
      n.wake = 1'b0;
      n.wake_svc = 1'b0;
      clr_div = 1'b0;
      go_stop = 1'b0;

      // first sync stage is read only by the second
      n.fc_s = {q.fc_s[1:0], fc_clk};
      n.fs_s = {q.fs_s[1:0], fs_clk};
      n.stp_s = {q.stp_s[1:0], stop_pin};
      fc_tick = q.fc_s[1] & ~q.fc_s[2] & q.flags[tg_pkg::FL_FAST_ON];
      fs_tick = q.fs_s[1] & ~q.fs_s[2] & q.flags[tg_pkg::FL_SLOW_ON];
      stp_rise = q.stp_s[1] & ~q.stp_s[2];
      stp_lvl = q.stp_s[1];

      // prescaler and divider chain
      pre_carry = fc_tick & ~front_stopped(q.mode) & (q.pre == 2'h3);
      lo_carry = pre_carry & (q.lo == 6'h3f);
      if ((q.mode == tg_pkg::stop_warm) && q.from_fast) begin
         in7 = lo_carry;
      end else if (main_is_slow(q.mode) ||
                   (q.mode == tg_pkg::stop_warm)) begin
         in7 = fs_tick;
      end else if (q.tbgc[tg_pkg::DV7_BIT]) begin
         in7 = fs_tick;
      end else begin
         in7 = lo_carry;
      end
      if (fc_tick & ~front_stopped(q.mode)) begin
         n.pre = q.pre + 2'h1;
      end
      if (pre_carry) begin
         n.lo = q.lo + 6'h01;
      end
      if (in7) begin
         n.hi = q.hi + 15'h0001;
      end

      // main clock and machine-cycle states
      if (main_is_slow(q.mode)) begin
         n.main_tick = fs_tick;
      end else if ((q.mode != tg_pkg::stop_hold) &&
                   (q.mode != tg_pkg::stop_warm)) begin
         n.main_tick = fc_tick;
      end
      if (q.main_tick) begin
         n.mstate = q.mstate + 2'h1;
      end

      // time-base falling edge for deep doze exit
      tap_now = tb_tap(q.tbgc[tg_pkg::TBCK_LSB +: 3], q.hi);
      n.tap_prev = tap_now;
      tap_fall = q.tap_prev & ~tap_now;

      // register writes
      wr_tbgc = wr && (addr == tg_pkg::TBGC_ADDR);
      wr_sc1 = wr && (addr == tg_pkg::SC1_ADDR);
      wr_sc2 = wr && (addr == tg_pkg::SC2_ADDR);
      if (wr_tbgc) begin
         n.tbgc = wdata;
      end
      if (wr_sc1) begin
         n.sc1 = wdata;
      end
      if (wr_sc2) begin
         n.sc2 = wdata & tg_pkg::SC2_WMASK;
      end

      // mode transitions
      unique case (q.mode)
         tg_pkg::single_clock_fast_run: begin
            if (wr_sc2 && wdata[tg_pkg::DOZE_BIT]) begin
               n.mode = tg_pkg::single_clock_doze;
            end else if (wr_sc2 && wdata[tg_pkg::HALT_BIT]) begin
               n.mode = tg_pkg::single_clock_deep_doze;
               n.tb_entry_en = q.tbgc[tg_pkg::TBEN_BIT];
            end else if (wr_sc2 && wdata[tg_pkg::SLOW_OSC_ENABLE_BIT]) begin
               n.mode = tg_pkg::fast_dual_run;
            end
            go_stop = wr_sc1 && wdata[tg_pkg::STOP_BIT];
         end
         tg_pkg::fast_dual_run: begin
            if (wr_sc2 && wdata[tg_pkg::DOZE_BIT]) begin
               n.mode = tg_pkg::fast_dual_doze;
            end else if (wr_sc2 && wdata[tg_pkg::MAIN_CLOCK_SELECT_BIT]) begin
               n.mode = tg_pkg::slow_dual_run;
            end else if (wr_sc2 && !wdata[tg_pkg::SLOW_OSC_ENABLE_BIT]) begin
               n.mode = tg_pkg::single_clock_fast_run;
            end
            go_stop = wr_sc1 && wdata[tg_pkg::STOP_BIT];
         end
         tg_pkg::slow_dual_run: begin
            if (wr_sc2 && wdata[tg_pkg::DOZE_BIT]) begin
               n.mode = tg_pkg::slow_dual_doze;
            end else if (wr_sc2 && wdata[tg_pkg::HALT_BIT]) begin
               n.mode = tg_pkg::slow_deep_doze;
               n.tb_entry_en = q.tbgc[tg_pkg::TBEN_BIT];
            end else if (wr_sc2 && !wdata[tg_pkg::MAIN_CLOCK_SELECT_BIT]) begin
               n.mode = tg_pkg::fast_dual_run;
            end else if (wr_sc2 && !wdata[tg_pkg::XEN_BIT]) begin
               n.mode = tg_pkg::slow_only_run;
            end
            go_stop = wr_sc1 && wdata[tg_pkg::STOP_BIT];
         end
         tg_pkg::slow_only_run: begin
            if (wr_sc2 && wdata[tg_pkg::DOZE_BIT]) begin
               n.mode = tg_pkg::slow_only_doze;
            end else if (wr_sc2 && wdata[tg_pkg::HALT_BIT]) begin
               n.mode = tg_pkg::slow_deep_doze;
               n.tb_entry_en = q.tbgc[tg_pkg::TBEN_BIT];
            end else if (wr_sc2 && wdata[tg_pkg::XEN_BIT]) begin
               n.mode = tg_pkg::slow_dual_run;
            end
            go_stop = wr_sc1 && wdata[tg_pkg::STOP_BIT];
         end
         tg_pkg::single_clock_doze, tg_pkg::fast_dual_doze,
         tg_pkg::slow_only_doze, tg_pkg::slow_dual_doze: begin
            if (irq_req) begin
               // doze bit clears itself on release
               n.sc2[tg_pkg::DOZE_BIT] = 1'b0;
               n.wake = 1'b1;
               n.wake_svc = master_interrupt_enable;
               if (q.mode == tg_pkg::single_clock_doze) begin
                  n.mode = tg_pkg::single_clock_fast_run;
               end else if (q.mode == tg_pkg::fast_dual_doze) begin
                  n.mode = tg_pkg::fast_dual_run;
               end else if (q.mode == tg_pkg::slow_only_doze) begin
                  n.mode = tg_pkg::slow_only_run;
               end else begin
                  n.mode = tg_pkg::slow_dual_run;
               end
            end
         end
         tg_pkg::single_clock_deep_doze, tg_pkg::slow_deep_doze: begin
            if (tap_fall) begin
               n.sc2[tg_pkg::HALT_BIT] = 1'b0;
               n.wake = 1'b1;
               n.tb_set = q.tb_entry_en;
               n.mode = (q.mode == tg_pkg::slow_deep_doze) ?
                  tg_pkg::slow_only_run :
                  tg_pkg::single_clock_fast_run;
            end
         end
         tg_pkg::stop_hold: begin
            // release by level or by rising edge of the stop pin
            if (q.sc1[tg_pkg::RELM_BIT] ? stp_lvl : stp_rise) begin
               n.mode = tg_pkg::stop_warm;
               n.warm = '0;
               clr_div = 1'b1;
            end
         end
         tg_pkg::stop_warm: begin
            if (q.ret_fast ? fc_tick : fs_tick) begin
               n.warm = q.warm + 16'h0001;
            end
            if (q.warm == tg_pkg::WARMUP_TICKS) begin
               n.sc1[tg_pkg::STOP_BIT] = 1'b0;
               n.wake = 1'b1;
               clr_div = 1'b1;
               if (!q.ret_fast) begin
                  n.mode = tg_pkg::slow_only_run;
               end else if (q.sc2[tg_pkg::SLOW_OSC_ENABLE_BIT]) begin
                  n.mode = tg_pkg::fast_dual_run;
               end else begin
                  n.mode = tg_pkg::single_clock_fast_run;
               end
            end
         end
         default: begin
            n.mode = tg_pkg::single_clock_fast_run;
         end
      endcase

      // stop entry holds state and remembers the return path
      if (go_stop) begin
         n.mode = tg_pkg::stop_hold;
         n.ret_fast = ~wdata[tg_pkg::RETM_BIT];
         n.from_fast = ~main_is_slow(q.mode);
         clr_div = 1'b1;
      end
      if (clr_div) begin
         n.pre = '0;
         n.lo = '0;
         n.hi = '0;
      end

      n.flags = mode_flags(n.mode, n.sc2[tg_pkg::SLOW_OSC_ENABLE_BIT], n.ret_fast);

      // read data, valid the cycle after the strobe; clock select reads
      // back the clock actually in use, not what was written
      sc2_rd = q.sc2;
      sc2_rd[tg_pkg::MAIN_CLOCK_SELECT_BIT] = q.flags[tg_pkg::FL_MAIN_SLOW];
      n.rdata = 8'h00;
      if (rd) begin
         if (addr == tg_pkg::TBGC_ADDR) begin
            n.rdata = q.tbgc;
         end else if (addr == tg_pkg::SC1_ADDR) begin
            n.rdata = q.sc1 & 8'hfc;
         end else if (addr == tg_pkg::SC2_ADDR) begin
            n.rdata = sc2_rd;
         end
      end
   end

   // single state register; synchronous reset
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q <= RST_Q;
      end else begin
         q <= n;
      end
   end

   // outputs taken straight from state bits
   assign rdata = q.rdata;
   assign mode = q.mode;
   assign cpu_halt = q.flags[tg_pkg::FL_CPU_HALT];
   assign wdt_halt = q.flags[tg_pkg::FL_CPU_HALT];
   assign periph_clk_en = q.flags[tg_pkg::FL_PERIPH_EN];
   assign tbt_clk_en = q.flags[tg_pkg::FL_TBT_EN];
   assign fast_osc_on = q.flags[tg_pkg::FL_FAST_ON];
   assign slow_osc_on = q.flags[tg_pkg::FL_SLOW_ON];
   assign slow_pins_are_port = q.flags[tg_pkg::FL_PINS_PORT];
   assign main_clk_slow = q.flags[tg_pkg::FL_MAIN_SLOW];
   assign main_tick = q.main_tick;
   assign machine_state = q.mstate;
   assign divider = {q.hi, q.lo, q.pre};
   assign time_base_interrupt_set = q.tb_set;
   assign wake = q.wake;
   assign wake_service = q.wake_svc;

endmodule

`default_nettype wire

// [verif/tg_props.sv]
// port checker for the timing generator mode control
// assumes a bind onto the design top and the single clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module tg_props (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wr,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic irq_req,
   input wire logic master_interrupt_enable,
   input wire logic [3:0] mode,
   input wire logic cpu_halt,
   input wire logic wdt_halt,
   input wire logic periph_clk_en,
   input wire logic tbt_clk_en,
   input wire logic slow_pins_are_port,
   input wire logic main_clk_slow,
   input wire logic main_tick,
   input wire logic [1:0] machine_state,
   input wire logic [22:0] divider,
   input wire logic time_base_interrupt_set,
   input wire logic wake,
   input wire logic wake_service
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // mode group decodes keep the properties short
   logic m_single, m_fast, m_slow, m_deep, m_low_off, sc2_wr;
   assign m_single = mode inside {tg_pkg::single_clock_fast_run,
      tg_pkg::single_clock_doze, tg_pkg::single_clock_deep_doze};
   assign m_fast = mode inside {tg_pkg::fast_dual_run, tg_pkg::fast_dual_doze};
   assign m_slow = mode inside {tg_pkg::slow_dual_run, tg_pkg::slow_only_run,
      tg_pkg::slow_only_doze, tg_pkg::slow_dual_doze};
   assign m_deep = mode inside {tg_pkg::single_clock_deep_doze,
      tg_pkg::slow_deep_doze};
   assign m_low_off = mode inside {tg_pkg::slow_only_run,
      tg_pkg::slow_only_doze, tg_pkg::slow_dual_doze};
   assign sc2_wr = wr && addr == tg_pkg::SC2_ADDR;

   // reset itself is the cause here, so no disable
   chk_reset_run: assert property (disable iff (1'b0)
      rst |=> mode == tg_pkg::single_clock_fast_run && divider == '0)
      else $error("mode or divider wrong after reset");
   chk_doze_entry: assert property (
      sc2_wr && wdata[tg_pkg::DOZE_BIT]
      && mode == tg_pkg::single_clock_fast_run
      |=> mode == tg_pkg::single_clock_doze && cpu_halt && wdt_halt)
      else $error("doze write did not halt the core");
   chk_doze_wake: assert property (
      mode == tg_pkg::single_clock_doze && irq_req
      |=> mode == tg_pkg::single_clock_fast_run && wake
      && wake_service == $past(master_interrupt_enable))
      else $error("doze release wrong");
   chk_idle_dual: assert property (
      mode == tg_pkg::fast_dual_doze && irq_req
      |=> mode == tg_pkg::fast_dual_run && wake)
      else $error("dual doze release wrong");
   chk_sleep_wake: assert property (
      mode == tg_pkg::slow_only_doze && irq_req
      |=> mode == tg_pkg::slow_only_run && wake)
      else $error("slow doze release wrong");
   chk_state_step: assert property (
      $changed(machine_state)
      |-> machine_state == $past(machine_state) + 2'd1)
      else $error("machine state skipped");
   chk_tick_state: assert property (
      main_tick |-> ##[0:1] $changed(machine_state))
      else $error("main tick did not advance state");
   chk_pins_port: assert property (
      m_single |-> slow_pins_are_port && !main_clk_slow)
      else $error("single clock pins or clock wrong");
   chk_dual_clock: assert property (
      m_fast || m_slow |-> !slow_pins_are_port && main_clk_slow == m_slow)
      else $error("dual clock pins or clock wrong");
   chk_deep_gate: assert property (
      m_deep |-> !periph_clk_en && cpu_halt)
      else $error("deep doze left peripherals clocked");
   chk_tbt_gate: assert property (
      tbt_clk_en == !(mode inside {tg_pkg::stop_hold, tg_pkg::stop_warm}))
      else $error("time base clock gate wrong");
   chk_low_stages: assert property (
      m_low_off ##1 m_low_off |-> $stable(divider[7:2]))
      else $error("low divider stages ran in slow mode");
   chk_stop_clear: assert property (
      mode == tg_pkg::stop_hold ##1 mode == tg_pkg::stop_hold
      |-> divider == '0 && cpu_halt)
      else $error("divider not held clear in stop");
   chk_deep_exit: assert property (
      $fell(mode == tg_pkg::single_clock_deep_doze)
      |-> mode == tg_pkg::single_clock_fast_run && wake)
      else $error("deep doze exit wrong");
   chk_tb_latch: assert property (
      time_base_interrupt_set |-> wake && (mode == tg_pkg::slow_only_run
      || mode == tg_pkg::single_clock_fast_run))
      else $error("time base latch outside deep doze exit");

   cover property (mode == tg_pkg::single_clock_doze && irq_req);
   cover property ($fell(mode == tg_pkg::slow_deep_doze));
   cover property ($fell(mode == tg_pkg::stop_warm));
   cover property (mode == tg_pkg::slow_dual_doze && irq_req);
endmodule

bind timing_generator_mode_control tg_props tg_props_i (.*);
`default_nettype wire

// [verif/tg_osc_model.sv]
// crystal model for the fast and slow oscillator pins
// assumes the enables come from the design; a stopped crystal holds low
`timescale 1ns/1ps
`default_nettype none
module tg_osc_model #(
   parameter int FC_HALF_NS = 10,
   parameter int FS_HALF_NS = 38
) (
   input wire logic fast_osc_on,
   input wire logic slow_osc_on,
   output logic fc_clk,
   output logic fs_clk
);
   // a pin stands still while its oscillator is off
   initial fc_clk = 1'b0;
   initial fs_clk = 1'b0;
   always #(FC_HALF_NS) fc_clk = (fast_osc_on === 1'b1) ? ~fc_clk : 1'b0;
   always #(FS_HALF_NS) fs_clk = (slow_osc_on === 1'b1) ? ~fs_clk : 1'b0;
endmodule
`default_nettype wire

// [verif/timing_generator_mode_control_bench.sv]
// self-checking bench for the timing generator mode control
// assumes tg_pkg, the design top, tg_osc_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module timing_generator_mode_control_bench;
   logic clk_sys = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic stop_pin = 1'b0, irq_req = 1'b0, master_interrupt_enable = 1'b0;
   logic [15:0] addr = '0;
   logic [7:0] wdata = '0, rdata, got;
   logic [5:0] low;
   logic [3:0] mode;
   logic [22:0] divider;
   logic cpu_halt, periph_clk_en, fast_osc_on, slow_osc_on, fc_clk, fs_clk;
   logic slow_pins_are_port, main_clk_slow, tb_set, wake, wake_service;
   logic tb_seen = 1'b0;
   int fails = 0, n_compared = 0, cyc = 0, n;
   typedef struct {logic w; logic [15:0] a; logic [7:0] d, e;} row_s;
   // reads of reset values, read-back, unmapped place refused
   row_s rows[8] = '{'{0, 16'h0036, 8'h00, 8'h00},
      '{0, 16'h0038, 8'h00, 8'h00}, '{0, 16'h0039, 8'h00, 8'h80},
      '{0, 16'h0037, 8'h00, 8'h00}, '{1, 16'h0036, 8'h0f, 8'h00},
      '{0, 16'h0036, 8'h00, 8'h0f}, '{1, 16'h0037, 8'hff, 8'h00},
      '{0, 16'h0037, 8'h00, 8'h00}};

   timing_generator_mode_control timing_generator_mode_control_i (
      .clk_sys, .rst, .addr, .wdata, .wr, .rd, .rdata, .fc_clk, .fs_clk,
      .stop_pin, .irq_req, .master_interrupt_enable, .mode, .cpu_halt,
      .wdt_halt(), .periph_clk_en, .tbt_clk_en(), .fast_osc_on,
      .slow_osc_on, .slow_pins_are_port, .main_clk_slow, .main_tick(),
      .machine_state(), .divider, .time_base_interrupt_set(tb_set), .wake,
      .wake_service);
   tg_osc_model tg_osc_model_i (.fast_osc_on, .slow_osc_on, .fc_clk,
      .fs_clk);

   // 4 ns period, cycle ceiling well above the longest wait chain
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         test_done();
      end
   end
   // the latch pulse lasts one cycle, so keep a sticky copy
   always @(posedge clk_sys) if (tb_set === 1'b1) tb_seen <= 1'b1;

   task automatic test_done;
      $display("fails=%0d compared=%0d", fails, n_compared);
      if (fails == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic cmpv(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t value %h expected %h", $time, g, e);
      end
   endtask
   task automatic cmpf(input logic g, input logic e);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t flag %b expected %b", $time, g, e);
      end
   endtask
   task automatic cmpm(input logic [3:0] e);
      n_compared++;
      if (mode !== e) begin
         fails++;
         $display("[FAIL] %0t mode %h expected %h", $time, mode, e);
      end
   endtask
   // bus tasks end mid-cycle so results can be sampled at once
   task automatic wreg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      wr <= 1'b0;
      @(negedge clk_sys);
   endtask
   task automatic rreg(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(negedge clk_sys);
      d = rdata;
   endtask
   task automatic pulse_irq;
      @(posedge clk_sys);
      irq_req <= 1'b1;
      @(posedge clk_sys);
      irq_req <= 1'b0;
      @(negedge clk_sys);
   endtask
   task automatic wait_mode(input logic [3:0] e, input int lim);
      n = 0;
      while (mode !== e && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
   endtask

   initial begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].w) wreg(rows[i].a, rows[i].d);
         else begin
            rreg(rows[i].a, got);
            cmpv(got, rows[i].e);
         end
      end
      cmpm(tg_pkg::single_clock_fast_run);
      // doze with both settings of the interrupt enable flag
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_sys);
         master_interrupt_enable <= k[0];
         wreg(16'h0039, 8'h90);
         cmpm(tg_pkg::single_clock_doze);
         cmpf(cpu_halt, 1'b1);
         pulse_irq();
         cmpm(tg_pkg::single_clock_fast_run);
         cmpf(wake_service, k[0]);
         rreg(16'h0039, got);
         cmpv(got, 8'h80);
      end
      wreg(16'h0039, 8'hc0);
      cmpm(tg_pkg::fast_dual_run);
      cmpf(slow_pins_are_port, 1'b0);
      wreg(16'h0039, 8'hd0);
      cmpm(tg_pkg::fast_dual_doze);
      pulse_irq();
      cmpm(tg_pkg::fast_dual_run);
      wreg(16'h0039, 8'he0);
      cmpm(tg_pkg::slow_dual_run);
      cmpf(main_clk_slow, 1'b1);
      // slow oscillator stays enabled while leaving slow dual run
      wreg(16'h0039, 8'h60);
      cmpm(tg_pkg::slow_only_run);
      wreg(16'h0039, 8'h70);
      cmpm(tg_pkg::slow_only_doze);
      low = divider[7:2];
      repeat (100) @(negedge clk_sys);
      cmpv({2'b00, divider[7:2]}, {2'b00, low});
      pulse_irq();
      cmpm(tg_pkg::slow_only_run);
      // slow deep doze with the time-base enable set
      wreg(16'h0039, 8'h64);
      cmpm(tg_pkg::slow_deep_doze);
      cmpf(periph_clk_en, 1'b0);
      wait_mode(tg_pkg::slow_only_run, 2000);
      repeat (4) @(negedge clk_sys);
      cmpm(tg_pkg::slow_only_run);
      cmpf(tb_seen, 1'b1);
      wreg(16'h0039, 8'he0);
      cmpm(tg_pkg::slow_dual_run);
      wreg(16'h0039, 8'hc0);
      cmpm(tg_pkg::fast_dual_run);
      wreg(16'h0039, 8'h80);
      cmpm(tg_pkg::single_clock_fast_run);
      // single deep doze with the time-base enable clear
      wreg(16'h0036, 8'h07);
      tb_seen = 1'b0;
      wreg(16'h0039, 8'h84);
      cmpm(tg_pkg::single_clock_deep_doze);
      cmpf(periph_clk_en, 1'b0);
      wait_mode(tg_pkg::single_clock_fast_run, 12000);
      repeat (4) @(negedge clk_sys);
      cmpm(tg_pkg::single_clock_fast_run);
      cmpf(tb_seen, 1'b0);
      // stop with level release, back to fast run after warm-up
      wreg(16'h0038, 8'hc0);
      cmpm(tg_pkg::stop_hold);
      repeat (20) @(negedge clk_sys);
      cmpf(|divider, 1'b0);
      cmpf(fast_osc_on, 1'b0);
      @(posedge clk_sys);
      stop_pin <= 1'b1;
      wait_mode(tg_pkg::stop_warm, 20);
      cmpm(tg_pkg::stop_warm);
      @(posedge clk_sys);
      stop_pin <= 1'b0;
      wait_mode(tg_pkg::single_clock_fast_run, 3000);
      cmpm(tg_pkg::single_clock_fast_run);
      rreg(16'h0038, got);
      cmpv(got, 8'h40);
      // slow dual doze, then stop from slow run with edge release
      wreg(16'h0039, 8'hc0);
      wreg(16'h0039, 8'he0);
      wreg(16'h0039, 8'hf0);
      cmpm(tg_pkg::slow_dual_doze);
      cmpf(fast_osc_on, 1'b1);
      pulse_irq();
      cmpm(tg_pkg::slow_dual_run);
      wreg(16'h0038, 8'ha0);
      cmpm(tg_pkg::stop_hold);
      @(posedge clk_sys);
      stop_pin <= 1'b1;
      wait_mode(tg_pkg::stop_warm, 20);
      cmpm(tg_pkg::stop_warm);
      @(posedge clk_sys);
      stop_pin <= 1'b0;
      // fs warm-up is slow: 256 ticks of about 19 cycles
      wait_mode(tg_pkg::slow_only_run, 6000);
      cmpm(tg_pkg::slow_only_run);
      wreg(16'h0039, 8'he0);
      cmpm(tg_pkg::slow_dual_run);
      // second reset from dual run
      wreg(16'h0039, 8'hc0);
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      @(negedge clk_sys);
      cmpm(tg_pkg::single_clock_fast_run);
      cmpf(cpu_halt, 1'b0);
      rreg(16'h0039, got);
      cmpv(got, 8'h80);
      rreg(16'h0036, got);
      cmpv(got, 8'h00);
      test_done();
   end
endmodule
`default_nettype wire
